/* File: shared/lsd_consts.svh */
// Constants for the segment LCD driver control block.
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH
`define LSD_CTRL_RESET 8'h00
`define LSD_MAIN_WMASK 8'hcf
`define LSD_BIAS_WMASK 8'hef
`define LSD_TYPE_BIT 7
`define LSD_RCT_BIT 6
`define LSD_RSEL_MSB 3
`define LSD_RSEL_LSB 1
`define LSD_EN_BIT 0
`define LSD_QCT_MSB 7
`define LSD_QCT_LSB 5
`define LSD_PANEL_SUPPLY_PIN_MSB 3
`define LSD_PANEL_SUPPLY_PIN_FULL_BIT 3
`define LSD_SEL_MAIN 1'h0
`define LSD_SECTOR_DISPLAY 8'h01
`define LSD_DISPLAY_BASE 8'h80
`define LSD_SEG_COUNT 56
`define LSD_SEG_LAST 8'hb7
`define LSD_SUB_DIV_LAST 3'h7
`define LSD_RATIO_BASE 5'h08
`define LSD_RATIO_FULL 5'h10
`endif

/* File: shared/lsd_pkg.sv */
// Types shared by the segment LCD driver control modules.
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_SLOT0 = 2'h0,
    LSD_SLOT1 = 2'h1,
    LSD_SLOT2 = 2'h3,
    LSD_SLOT3 = 2'h2
  } lsd_slot_e;
  typedef enum logic [1:0] {
    LSD_R1170 = 2'h0,
    LSD_R225 = 2'h1,
    LSD_R60 = 2'h2
  } lsd_res_e;
endpackage : lsd_pkg

/* File: shared/lsd_qc_if.sv */
// Link between the scan controller and the quick-charge timer.
`timescale 1ns/100ps
interface lsd_qc_if;
  logic start;
  logic [2:0] period;
  logic subEdge;
  logic active;
  modport ctrl (output start, output period, output subEdge, input active);
  modport timer (input start, input period, input subEdge, output active);
endinterface : lsd_qc_if

/* File: logic/lsd_quick_charge.sv */
// Quick-charge duration timer counted in sub-clock periods.
`timescale 1ns/100ps
module lsd_quick_charge
  import lsd_pkg::*;
(
  input wire logic clock,
  input wire logic clkEn,
  input wire logic nrst,
  lsd_qc_if.timer qc
);
  logic [3:0] count_reg;
  logic [3:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (qc.start) begin
      count_next = {1'b0, qc.period} + 4'h1; // RULE_18
    end else if (qc.subEdge && count_reg != 4'h0) begin
      count_next = count_reg - 4'h1; // RULE_11
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 4'h0;
    end else if (clkEn) begin
      count_reg <= count_next;
    end
  end

  assign qc.active = (count_reg != 4'h0);
endmodule : lsd_quick_charge

/* File: logic/lsd_segment_driver_control.sv */
// Segment LCD driver control: registers, display memory and 1/4 duty scan.
// Notes on behaviour
// RULE_01: Display sector is chosen when the pointer high byte holds one.
// RULE_02: In that sector, indirect accesses from address 80h hit display memory.
// RULE_03: Display memory is fetched continuously so writes show up at once.
// RULE_04: LCD clock is the sub-clock divided by eight.
// RULE_05: Enable bit 0 turns display on; sleep always forces it off.
// RULE_06: Bit 7 selects waveform type A (zero) or faster-scanning type B (one).
// RULE_07: Bit 6 selects resistor bias (zero) or capacitor bias (one).
// RULE_08: Capacitor bias enables the charge pump; resistor bias keeps it off.
// RULE_09: Resistor codes 000, 001, 010 pick 1170k, 225k, 60k.
// RULE_10: Code 011 alternates 60k/1170k; codes 1xx alternate 60k/225k.
// RULE_11: Quick charge lasts period field plus one sub-clock periods.
// RULE_12: Top level is (8+code)/16 of supply, full supply when bit 3 set.
// RULE_13: Unimplemented control bits read zero and ignore writes.
// RULE_14: Quarter duty: four commons, four time slots per frame.
// RULE_15: Display enable is zero after power-on.
// RULE_16: Software must initialise display memory after power-on.
// RULE_17: All control bits reset to zero.
// RULE_18: Quick-charge counter reloads from the period field at each start.
`timescale 1ns/100ps
`include "lsd_consts.svh"
module lsd_segment_driver_control
  import lsd_pkg::*;
(
  input wire logic clock,
  input wire logic clkEn,
  input wire logic nrst,
  input wire logic sleepMode,
  input wire logic subClock,
  input wire logic sfrWrite,
  input wire logic sfrSel,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] ctrlMainValue,
  output logic [7:0] biasTimingValue,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic [7:0] sectorByte,
  input wire logic [7:0] lowByte,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  output logic displayHit,
  output logic [3:0] comActive,
  output logic framePolarity,
  output logic [55:0] segOn,
  output logic chargePumpEnable,
  output lsd_res_e resistorSel,
  output logic quickChargeActive,
  output logic [4:0] topRatio
);
  lsd_qc_if qcLink ();

  logic [7:0] main_reg, main_next;
  logic [7:0] bias_reg, bias_next;
  logic [7:0] rdData_reg, rdData_next;
  logic [3:0] dispMem [0:`LSD_SEG_COUNT-1];
  logic [5:0] memIndex;
  logic inRange, memWe;
  logic subSync1_reg, subSync2_reg, subPrev_reg;
  logic subEdge, lcdTick, displayOn, slotAdvance;
  logic [2:0] div_reg, div_next;
  lsd_slot_e slot_reg, slot_next;
  logic phase_reg, phase_next;
  logic pol_reg, pol_next;
  logic [1:0] slotIdx;
  logic [55:0] seg_reg, seg_next;
  logic [3:0] com_reg, com_next;
  logic pump_reg, pump_next;
  lsd_res_e res_reg, res_next;
  logic [4:0] ratio_reg, ratio_next;

  // Control registers; unimplemented bits are masked on write.
  always_comb begin
    main_next = main_reg;
    bias_next = bias_reg;
    if (sfrWrite) begin
      if (sfrSel == `LSD_SEL_MAIN) begin
        main_next = sfrWdata & `LSD_MAIN_WMASK; // RULE_13
      end else begin
        bias_next = sfrWdata & `LSD_BIAS_WMASK; // RULE_13
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_reg <= `LSD_CTRL_RESET; // RULE_15 RULE_17
      bias_reg <= `LSD_CTRL_RESET; // RULE_17
    end else if (clkEn) begin
      main_reg <= main_next;
      bias_reg <= bias_next;
    end
  end

  assign ctrlMainValue = main_reg;
  assign biasTimingValue = bias_reg;

  // Display memory decode. Addresses past the last segment read zero.
  assign displayHit = (sectorByte == `LSD_SECTOR_DISPLAY) && (lowByte >= `LSD_DISPLAY_BASE); // RULE_01 RULE_02
  assign memIndex = 6'(lowByte - `LSD_DISPLAY_BASE);
  assign inRange = displayHit && (lowByte <= `LSD_SEG_LAST);
  assign memWe = memWrite && inRange; // RULE_02

  always_comb begin
    rdData_next = rdData_reg;
    if (memRead && displayHit) begin
      rdData_next = inRange ? {4'h0, dispMem[memIndex]} : 8'h00;
    end
  end

  // Memory holds no reset: its contents are undefined until software fills it.
  always_ff @(posedge clock) begin
    if (clkEn && memWe) begin
      dispMem[memIndex] <= memWdata[3:0];
    end
  end

  // The sub-clock comes from another oscillator, so it is synchronised first.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      subSync1_reg <= 1'b0;
      subSync2_reg <= 1'b0;
      subPrev_reg <= 1'b0;
    end else if (clkEn) begin
      subSync1_reg <= subClock;
      subSync2_reg <= subSync1_reg;
      subPrev_reg <= subSync2_reg;
    end
  end

  assign subEdge = subSync2_reg && !subPrev_reg;
  assign displayOn = main_reg[`LSD_EN_BIT] && !sleepMode; // RULE_05
  assign lcdTick = displayOn && subEdge && (div_reg == `LSD_SUB_DIV_LAST); // RULE_04

  always_comb begin
    case (slot_reg)
      LSD_SLOT0: slotIdx = 2'h0;
      LSD_SLOT1: slotIdx = 2'h1;
      LSD_SLOT2: slotIdx = 2'h2;
      LSD_SLOT3: slotIdx = 2'h3;
      default: slotIdx = 2'h0;
    endcase
  end

  // Type A flips polarity inside every slot; type B flips once per frame.
  always_comb begin
    div_next = div_reg;
    slot_next = slot_reg;
    phase_next = phase_reg;
    pol_next = pol_reg;
    slotAdvance = 1'b0;
    if (!displayOn) begin
      div_next = 3'h0;
      slot_next = LSD_SLOT0;
      phase_next = 1'b0;
      pol_next = 1'b0;
    end else begin
      if (subEdge) begin
        div_next = div_reg + 3'h1; // RULE_04
      end
      if (lcdTick) begin
        if (!main_reg[`LSD_TYPE_BIT]) begin
          pol_next = !pol_reg; // RULE_06
          phase_next = !phase_reg;
          slotAdvance = phase_reg;
        end else begin
          slotAdvance = 1'b1; // RULE_06
          if (slot_reg == LSD_SLOT3) begin
            pol_next = !pol_reg;
          end
        end
      end
      if (slotAdvance) begin
        case (slot_reg) // RULE_14
          LSD_SLOT0: slot_next = LSD_SLOT1;
          LSD_SLOT1: slot_next = LSD_SLOT2;
          LSD_SLOT2: slot_next = LSD_SLOT3;
          LSD_SLOT3: slot_next = LSD_SLOT0;
          default: slot_next = LSD_SLOT0;
        endcase
      end
    end
  end

  // Pixel states are refetched every cycle for the slot being driven.
  always_comb begin
    seg_next = 56'h0;
    com_next = 4'h0;
    if (displayOn) begin
      com_next = 4'h1 << slotIdx; // RULE_14
      for (int i = 0; i < `LSD_SEG_COUNT; i++) begin
        seg_next[i] = dispMem[i][slotIdx]; // RULE_03
      end
    end
  end

  assign qcLink.start = slotAdvance && (main_reg[`LSD_RSEL_MSB:`LSD_RSEL_LSB] >= 3'h3) &&
                        !main_reg[`LSD_RCT_BIT]; // RULE_18
  assign qcLink.period = bias_reg[`LSD_QCT_MSB:`LSD_QCT_LSB];
  assign qcLink.subEdge = subEdge;

  lsd_quick_charge qcTimer (
    .clock(clock),
    .clkEn(clkEn),
    .nrst(nrst),
    .qc(qcLink)
  );

  always_comb begin
    pump_next = displayOn && main_reg[`LSD_RCT_BIT]; // RULE_07 RULE_08
    case (main_reg[`LSD_RSEL_MSB:`LSD_RSEL_LSB])
      3'h0: res_next = LSD_R1170; // RULE_09
      3'h1: res_next = LSD_R225;
      3'h2: res_next = LSD_R60;
      3'h3: res_next = qcLink.active ? LSD_R60 : LSD_R1170; // RULE_10
      default: res_next = qcLink.active ? LSD_R60 : LSD_R225; // RULE_10
    endcase
    if (bias_reg[`LSD_PANEL_SUPPLY_PIN_FULL_BIT]) begin
      ratio_next = `LSD_RATIO_FULL; // RULE_12
    end else begin
      ratio_next = `LSD_RATIO_BASE + {2'h0, bias_reg[`LSD_PANEL_SUPPLY_PIN_MSB-1:0]}; // RULE_12
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 3'h0;
      slot_reg <= LSD_SLOT0;
      phase_reg <= 1'b0;
      pol_reg <= 1'b0;
      seg_reg <= 56'h0;
      com_reg <= 4'h0;
      pump_reg <= 1'b0;
      res_reg <= LSD_R1170;
      ratio_reg <= `LSD_RATIO_BASE;
      rdData_reg <= 8'h00;
    end else if (clkEn) begin
      div_reg <= div_next;
      slot_reg <= slot_next;
      phase_reg <= phase_next;
      pol_reg <= pol_next;
      seg_reg <= seg_next;
      com_reg <= com_next;
      pump_reg <= pump_next;
      res_reg <= res_next;
      ratio_reg <= ratio_next;
      rdData_reg <= rdData_next;
    end
  end

  assign memRdata = rdData_reg;
  assign comActive = com_reg;
  assign framePolarity = pol_reg;
  assign segOn = seg_reg;
  assign chargePumpEnable = pump_reg;
  assign resistorSel = res_reg;
  assign quickChargeActive = qcLink.active;
  assign topRatio = ratio_reg;
endmodule : lsd_segment_driver_control

/* File: tb/lsd_ctrl_monitor.sv */
// Checker for the ports of the segment LCD driver control block.
`timescale 1ns/100ps
`include "lsd_consts.svh"
module lsd_ctrl_monitor
  import lsd_pkg::*;
(
  input wire logic clock,
  input wire logic clkEn,
  input wire logic nrst,
  input wire logic sleepMode,
  input wire logic sfrWrite,
  input wire logic sfrSel,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] ctrlMainValue,
  input wire logic [7:0] biasTimingValue,
  input wire logic [7:0] sectorByte,
  input wire logic [7:0] lowByte,
  input wire logic displayHit,
  input wire logic [3:0] comActive,
  input wire logic [55:0] segOn,
  input wire logic chargePumpEnable,
  input wire lsd_res_e resistorSel,
  input wire logic quickChargeActive,
  input wire logic [4:0] topRatio
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_off;
    (sleepMode || !ctrlMainValue[`LSD_EN_BIT])[*2];
  endsequence
  sequence s_main_wr;
    sfrWrite && clkEn && !sfrSel;
  endsequence
  chk_unused_bits: assert property (ctrlMainValue[5:4] == 2'h0 && !biasTimingValue[4])
    else $error("unused control bit set");
  chk_main_write: assert property (s_main_wr |=> ctrlMainValue == ($past(sfrWdata) & `LSD_MAIN_WMASK))
    else $error("main control write lost");
  chk_sector_hit: assert property (displayHit == (sectorByte == `LSD_SECTOR_DISPLAY && lowByte >= 8'h80))
    else $error("display hit wrong");
  chk_off_blank: assert property (s_off |-> comActive == 4'h0 && segOn == 56'h0)
    else $error("display not blank when off");
  chk_one_common: assert property ($onehot0(comActive))
    else $error("more than one common active");
  chk_pump_bias: assert property (chargePumpEnable ==
    $past(ctrlMainValue[`LSD_RCT_BIT] && ctrlMainValue[`LSD_EN_BIT] && !sleepMode))
    else $error("pump state does not follow bias and enable");
  chk_top_ratio: assert property (topRatio == ($past(biasTimingValue[3]) ? 5'h10 :
    5'h08 + {2'h0, $past(biasTimingValue[2:0])}))
    else $error("top ratio wrong");
  chk_fixed_res: assert property ($past(ctrlMainValue[3:1]) < 3'h3 && !$past(quickChargeActive)
    |-> resistorSel == $past(ctrlMainValue[2:1]))
    else $error("fixed resistor wrong");
  chk_qc_low: assert property ($past(ctrlMainValue[3:1]) >= 3'h3 && $past(quickChargeActive) &&
    quickChargeActive |-> resistorSel == LSD_R60)
    else $error("quick charge not on low resistor");
endmodule : lsd_ctrl_monitor
bind lsd_segment_driver_control lsd_ctrl_monitor u_mon (
  .clock(clock),
  .clkEn(clkEn),
  .nrst(nrst),
  .sleepMode(sleepMode),
  .sfrWrite(sfrWrite),
  .sfrSel(sfrSel),
  .sfrWdata(sfrWdata),
  .ctrlMainValue(ctrlMainValue),
  .biasTimingValue(biasTimingValue),
  .sectorByte(sectorByte),
  .lowByte(lowByte),
  .displayHit(displayHit),
  .comActive(comActive),
  .segOn(segOn),
  .chargePumpEnable(chargePumpEnable),
  .resistorSel(resistorSel),
  .quickChargeActive(quickChargeActive),
  .topRatio(topRatio)
);

/* File: tb/lsd_panel_model.sv */
// Passive panel model that keeps the pixel pattern last shown on each common.
`timescale 1ns/100ps
module lsd_panel_model (
  input wire logic clock,
  input wire logic [3:0] comActive,
  input wire logic [55:0] segOn,
  output logic [55:0] shown [4]
);
  always @(posedge clock) begin
    for (int c = 0; c < 4; c++) begin
      if (comActive[c]) begin
        shown[c] <= segOn;
      end
    end
  end
endmodule : lsd_panel_model

/* File: tb/lsd_segment_driver_control_test.sv */
// Self-checking bench for the segment LCD driver control block.
`timescale 1ns/100ps
module lsd_segment_driver_control_test
  import lsd_pkg::*;
;
  logic clock, nrst, clkEn, sleepMode, subClock, sfrWrite, sfrSel, memWrite, memRead;
  logic [7:0] sfrWdata, ctrlMainValue, biasTimingValue, sectorByte, lowByte, memWdata, memRdata;
  logic displayHit, framePolarity, chargePumpEnable, quickChargeActive;
  logic [3:0] comActive;
  logic [55:0] segOn;
  logic [55:0] shown [4];
  logic [4:0] topRatio;
  lsd_res_e resistorSel;
  int nFail = 0;
  int nCompared = 0;
  int cyc;
  lsd_segment_driver_control u_dut (
    .clock(clock),
    .clkEn(clkEn),
    .nrst(nrst),
    .sleepMode(sleepMode),
    .subClock(subClock),
    .sfrWrite(sfrWrite),
    .sfrSel(sfrSel),
    .sfrWdata(sfrWdata),
    .ctrlMainValue(ctrlMainValue),
    .biasTimingValue(biasTimingValue),
    .memWrite(memWrite),
    .memRead(memRead),
    .sectorByte(sectorByte),
    .lowByte(lowByte),
    .memWdata(memWdata),
    .memRdata(memRdata),
    .displayHit(displayHit),
    .comActive(comActive),
    .framePolarity(framePolarity),
    .segOn(segOn),
    .chargePumpEnable(chargePumpEnable),
    .resistorSel(resistorSel),
    .quickChargeActive(quickChargeActive),
    .topRatio(topRatio)
  );
  lsd_panel_model u_panel (.clock, .comActive, .segOn, .shown);
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // The sub-clock runs far faster than a real one so a frame fits in a short run.
  initial begin
    subClock = 1'h0;
    #7;
    forever #250 subClock = ~subClock;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic completeRun();
    $display("Compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : completeRun
  task automatic sfrWr(input logic sel, input logic [7:0] d);
    sfrWrite <= 1'h1;
    sfrSel <= sel;
    sfrWdata <= d;
    @(posedge clock);
    sfrWrite <= 1'h0;
    repeat (2) @(posedge clock);
  endtask : sfrWr
  task automatic memAcc(input logic wr, input logic [7:0] sec, input logic [7:0] a, input logic [7:0] d);
    memWrite <= wr;
    memRead <= !wr;
    sectorByte <= sec;
    lowByte <= a;
    memWdata <= d;
    @(posedge clock);
    memWrite <= 1'h0;
    memRead <= 1'h0;
    @(posedge clock);
  endtask : memAcc
  task automatic nextSlot(output int n);
    logic [3:0] prev;
    prev = comActive;
    n = 0;
    while (comActive === prev && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000) nFail++;
  endtask : nextSlot
  // Times one quick charge; a partial first charge after enabling is skipped.
  task automatic qcRun(input logic [7:0] mainVal, input int sub, input lsd_res_e rest);
    sfrWr(1'h0, mainVal);
    nextSlot(cyc);
    nextSlot(cyc);
    repeat (3) @(posedge clock);
    check(resistorSel, LSD_R60);
    cyc = 0;
    while (quickChargeActive === 1'h1 && cyc < 3000) begin
      @(posedge clock);
      cyc++;
    end
    check((cyc + 13) / 20, sub);
    repeat (2) @(posedge clock);
    check(resistorSel, rest);
  endtask : qcRun
  initial begin
    repeat (20000) @(posedge clock);
    nFail++;
    completeRun();
  end
  initial begin
    {nrst, sleepMode, sfrWrite, sfrSel, memWrite, memRead} = 6'h0;
    clkEn = 1'h1;
    {sfrWdata, sectorByte, lowByte, memWdata} = 32'h0;
    repeat (3) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    check({ctrlMainValue, biasTimingValue, topRatio, comActive}, {16'h0, 5'h08, 4'h0});
    sfrWr(1'h0, 8'hff);
    check(ctrlMainValue, 8'hcf);
    check(chargePumpEnable, 1'h1);
    for (int i = 0; i < 16; i++) begin
      sfrWr(1'h1, 8'hf0 | i[7:0]);
      check(biasTimingValue, 8'he0 | i[7:0]);
      check(topRatio, i[3] ? 5'h10 : 5'h08 + i[4:0]);
    end
    clkEn <= 1'h0;
    sfrWr(1'h1, 8'h00);
    check({biasTimingValue, topRatio}, {8'hef, 5'h10});
    clkEn <= 1'h1;
    sfrWr(1'h0, 8'h40);
    check({chargePumpEnable, comActive}, 5'h0);
    for (int r = 0; r < 3; r++) begin
      sfrWr(1'h0, r[6:0] << 1);
      check(resistorSel, r);
    end
    for (int a = 0; a < 56; a++) begin
      memAcc(1'h1, 8'h01, 8'h80 + a[7:0], 8'h00);
    end
    memAcc(1'h1, 8'h01, 8'h80, 8'hf5);
    memAcc(1'h1, 8'h01, 8'hb7, 8'h0a);
    memAcc(1'h1, 8'h00, 8'h80, 8'h0f);
    memAcc(1'h0, 8'h01, 8'h80, 8'h00);
    check({displayHit, memRdata}, 9'h105);
    memAcc(1'h0, 8'h01, 8'hb7, 8'h00);
    check(memRdata, 8'h0a);
    memAcc(1'h0, 8'h00, 8'h80, 8'h00);
    check({displayHit, memRdata}, 9'h00a);
    memAcc(1'h0, 8'h01, 8'hb8, 8'h00);
    check(memRdata, 8'h00);
    sfrWr(1'h0, 8'h01);
    check(chargePumpEnable, 1'h0);
    for (int k = 0; k < 6; k++) begin
      nextSlot(cyc);
      if (k > 1) check(cyc, 320);
      check(comActive, 4'h1 << ((k + 1) % 4));
      check({segOn[55], segOn[0]}, {1'(8'h0a >> ((k + 1) % 4)), 1'(8'h05 >> ((k + 1) % 4))});
      check(framePolarity, 1'h0);
    end
    repeat (170) @(posedge clock);
    check(framePolarity, 1'h1);
    check({shown[2][0], shown[1][0], shown[3][55]}, 3'h5);
    memAcc(1'h1, 8'h01, 8'h80, 8'h0f);
    nextSlot(cyc);
    check(segOn[0], 1'h1);
    sfrWr(1'h0, 8'h81);
    nextSlot(cyc);
    nextSlot(cyc);
    check(cyc, 160);
    sleepMode <= 1'h1;
    repeat (3) @(posedge clock);
    check({comActive, segOn}, 60'h0);
    sleepMode <= 1'h0;
    sfrWr(1'h1, 8'h00);
    qcRun(8'h07, 1, LSD_R1170);
    sfrWr(1'h1, 8'he0);
    qcRun(8'h09, 8, LSD_R225);
    completeRun();
  end
endmodule : lsd_segment_driver_control_test
